// *** design/coproc_pkg.sv ***
// Constants shared by the processor end and the coprocessor end.
// Assumes one clock (clk) and a synchronous active-high reset (rst).
// Operation
// (RULE_01) Up to sixteen coprocessors, selected by number field.
// (RULE_02) Absent and busy idle high unless handshaking.
// (RULE_03) Strobe low on executed coprocessor/undefined instruction.
// (RULE_04) Matching coprocessor drives absent low to claim.
// (RULE_05) Nobody claims: processor takes undefined trap.
// (RULE_06) Only claiming coprocessor drives busy low when ready.
// (RULE_07) Busy-wait; enabled interrupt abandons the handshake.
// (RULE_08) All handshake lines sampled on rising clock edge.
// (RULE_09) All three low commits; transfers start next cycle.
// (RULE_10) Strobe high before commit: coprocessor discards instruction.
// (RULE_11) Data operations complete at not-busy, no transfers.
// (RULE_12) Coprocessor copies fetched words into own pipeline.
// (RULE_13) One word per clock, direction from load bit.
// (RULE_14) Address steps one word; absent+busy high ends.
// (RULE_15) Coprocessor allows at most sixteen transfer words.
// (RULE_16) Processor not interruptible once transfers have begun.
// (RULE_17) Register transfer: request and sequential both high.
// (RULE_18) Bus enable when free; one clock times transfer.
// (RULE_19) Privileged instructions gated by user-mode output.
// (RULE_20) Actions before not-busy are repeatable.
// (RULE_21) Register result presented cycle after not-busy.
// (RULE_22) Bit 27 zero means undefined: stay absent.

package coproc_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int CP_COUNT = 16;
	localparam int CPNUM_LSB = 8;
	localparam int CPNUM_W = 4;
	localparam int CLASS_BIT = 27;
	localparam int CLASS_LSB = 24;
	localparam int LOAD_BIT = 20;
	localparam int MAX_WORDS = 16;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [31:0] INSTR_RESET = 32'h0000_0000;
	localparam logic [7:0] OP_LATENCY = 8'h03;

	// Instruction kinds seen on the handshake
	typedef enum logic [1:0] {
		KIND_DATA_OP = 2'h0,
		KIND_MEM_XFER = 2'h1,
		KIND_REG_XFER = 2'h2
	} kind_type;

	function automatic kind_type decode_kind(input logic [31:0] ins);
		if (ins[CLASS_LSB + 1])
			decode_kind = ins[4] ? KIND_REG_XFER : KIND_DATA_OP;
		else
			decode_kind = KIND_MEM_XFER;
	endfunction
endpackage

// *** design/coproc_if.sv ***
// Coprocessor handshake and shared data bus between the two ends.
// Assumes the testbench resolves the data bus from the two enables.
`timescale 1ns/100ps

interface coproc_if;
	logic coproc_instr_strobe_n;
	logic coproc_absent;
	logic coproc_busy;
	logic opcode_fetch_n;
	logic memory_request_n;
	logic sequential_cycle;
	logic translate_user_n;
	logic data_bus_enable;
	logic [31:0] addr;
	logic [31:0] cpu_dout;
	logic cpu_doe;
	logic [31:0] cp_dout;
	logic cp_doe;
	logic [31:0] bus_din;

	modport processor (
		output coproc_instr_strobe_n,
		input coproc_absent,
		input coproc_busy,
		output opcode_fetch_n,
		output memory_request_n,
		output sequential_cycle,
		output translate_user_n,
		output addr,
		output cpu_dout,
		output cpu_doe,
		input data_bus_enable,
		input bus_din
	);

	modport coprocessor (
		input coproc_instr_strobe_n,
		output coproc_absent,
		output coproc_busy,
		input opcode_fetch_n,
		input memory_request_n,
		input sequential_cycle,
		input translate_user_n,
		input data_bus_enable,
		output cp_dout,
		output cp_doe,
		input bus_din
	);
endinterface

// *** design/instr_pipe.sv ***
// Three-stage copy of the fetched instruction stream.
// Assumes fetch_n marks a word on din that is an instruction fetch.
`timescale 1ns/100ps

module instr_pipe #(
	parameter int DEPTH = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic fetch_n,
	input wire logic [31:0] din,
	output logic [31:0] exec_instr
);
	logic [31:0] stage_r [DEPTH];
	logic [31:0] stage_nxt [DEPTH];

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			stage_nxt[i] = stage_r[i];
		end
		if (!fetch_n) begin // RULE_12
			stage_nxt[0] = din;
			for (int i = 1; i < DEPTH; i++) begin
				stage_nxt[i] = stage_r[i - 1];
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (rst)
				stage_r[i] <= coproc_pkg::INSTR_RESET;
			else
				stage_r[i] <= stage_nxt[i];
		end
	end

	assign exec_instr = stage_r[DEPTH - 1];
endmodule

// *** design/coproc_end.sv ***
// Coprocessor end: claims, busy handshake and data transfers.
// Assumes the processor keeps its own side of the handshake.
`timescale 1ns/100ps

module coproc_end #(
	parameter logic [3:0] MY_NUMBER = 4'h1,
	parameter logic PRIV_ONLY = 1'b0,
	parameter int WORDS = 4
) (
	input wire logic clk,
	input wire logic rst,
	coproc_if.coprocessor bus,
	input wire logic enabled,
	input wire logic [31:0] reg_value,
	output logic [31:0] load_word,
	output logic load_valid,
	output logic committed,
	output logic discarded
);
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_BUSY = 5'b00010,
		S_XFER = 5'b00100,
		S_REG = 5'b01000,
		S_DONE = 5'b10000
	} state_type;

	localparam int CNT_W = 5;
	localparam int CAP = (WORDS > coproc_pkg::MAX_WORDS) ?
		coproc_pkg::MAX_WORDS : WORDS;

	state_type state_r, state_nxt;
	logic [7:0] wait_r, wait_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [31:0] out_r, out_nxt;
	logic [31:0] ld_r, ld_nxt;
	logic ldv_r, ldv_nxt;
	logic [31:0] instr;
	logic mine, load_dir, priv_ok, was_strobed_r, strobed_nxt;
	coproc_pkg::kind_type kind;

	instr_pipe #(.DEPTH(3)) instr_pipe_inst (
		.clk(clk),
		.rst(rst),
		.fetch_n(bus.opcode_fetch_n),
		.din(bus.bus_din),
		.exec_instr(instr)
	);

	assign kind = coproc_pkg::decode_kind(instr);
	assign load_dir = instr[coproc_pkg::LOAD_BIT]; // RULE_13
	assign priv_ok = !PRIV_ONLY || bus.translate_user_n; // RULE_19
	assign mine = instr[coproc_pkg::CLASS_BIT] && enabled && priv_ok && // RULE_22
		(instr[coproc_pkg::CPNUM_LSB +: coproc_pkg::CPNUM_W] == MY_NUMBER);

	always_comb begin
		state_nxt = state_r;
		wait_nxt = wait_r;
		cnt_nxt = cnt_r;
		out_nxt = out_r;
		ld_nxt = ld_r;
		ldv_nxt = 1'b0;
		strobed_nxt = was_strobed_r;
		case (state_r)
			S_IDLE: begin
				strobed_nxt = 1'b0;
				if (!bus.coproc_instr_strobe_n && mine) begin // RULE_04
					state_nxt = S_BUSY;
					wait_nxt = coproc_pkg::OP_LATENCY;
					strobed_nxt = 1'b1;
				end
			end
			S_BUSY: begin
				// Nothing irreversible happens here
				if (bus.coproc_instr_strobe_n) begin // RULE_10 RULE_20
					state_nxt = S_IDLE;
				end else if (wait_r == 8'h00) begin
					// Sampled all low: committed
					out_nxt = reg_value; // RULE_21
					cnt_nxt = '0;
					case (kind)
						coproc_pkg::KIND_DATA_OP: state_nxt = S_DONE; // RULE_11
						coproc_pkg::KIND_REG_XFER: state_nxt = S_REG;
						default: state_nxt = S_XFER; // RULE_09
					endcase
				end else begin
					wait_nxt = wait_r - 8'h01;
				end
			end
			S_XFER: begin
				if (load_dir && bus.data_bus_enable) begin
					ld_nxt = bus.bus_din;
					ldv_nxt = 1'b1;
				end
				cnt_nxt = cnt_r + 5'd1;
				out_nxt = out_r + 32'h0000_0001;
				if (cnt_r == CNT_W'(CAP - 1)) // RULE_15
					state_nxt = S_DONE;
			end
			S_REG: begin
				// Hold the cycle until the bus is granted
				if (bus.data_bus_enable) begin // RULE_18
					if (!load_dir) begin
						ld_nxt = bus.bus_din;
						ldv_nxt = 1'b1;
					end
					state_nxt = S_DONE;
				end
			end
			S_DONE: state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin // RULE_08
		if (rst) begin
			state_r <= S_IDLE;
			wait_r <= 8'h00;
			cnt_r <= '0;
			out_r <= coproc_pkg::INSTR_RESET;
			ld_r <= coproc_pkg::INSTR_RESET;
			ldv_r <= 1'b0;
			was_strobed_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			wait_r <= wait_nxt;
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
			ld_r <= ld_nxt;
			ldv_r <= ldv_nxt;
			was_strobed_r <= strobed_nxt;
		end
	end

	// Absent low while claimed or before the last memory word; high otherwise
	assign bus.coproc_absent = !(state_r == S_BUSY || // RULE_02 RULE_14
		(state_r == S_XFER && cnt_r != CNT_W'(CAP - 1)));
	assign bus.coproc_busy = !((state_r == S_BUSY && wait_r == 8'h00) || // RULE_06
		(state_r == S_XFER && cnt_r != CNT_W'(CAP - 1)));
	assign bus.cp_dout = out_r;
	// Stores out of the coprocessor and reads back to the processor drive
	assign bus.cp_doe = bus.data_bus_enable && // RULE_13
		((state_r == S_XFER && !load_dir) ||
		(state_r == S_REG && load_dir));
	assign load_word = ld_r;
	assign load_valid = ldv_r;
	assign committed = (state_r == S_BUSY) && (state_nxt != S_IDLE) &&
		(state_nxt != S_BUSY);
	assign discarded = (state_r == S_BUSY) && bus.coproc_instr_strobe_n &&
		was_strobed_r;
endmodule

// *** design/cpu_end.sv ***
// Processor end of the coprocessor handshake.
// Assumes a user-side request per instruction and one coprocessor bus.
`timescale 1ns/100ps

module cpu_end (
	input wire logic clk,
	input wire logic rst,
	coproc_if.processor bus,
	input wire logic start,
	input wire logic cond_pass,
	input wire logic [31:0] instr,
	input wire logic [31:0] base_addr,
	input wire logic [31:0] store_word,
	input wire logic irq,
	input wire logic user_mode,
	input wire logic fetch,
	output logic ready,
	output logic undef_trap,
	output logic irq_taken,
	output logic done,
	output logic [31:0] reg_result
);
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_WAIT = 5'b00010,
		S_XFER = 5'b00100,
		S_REG = 5'b01000,
		S_FIN = 5'b10000
	} state_type;

	state_type state_r, state_nxt;
	logic [31:0] addr_r, addr_nxt;
	logic [31:0] res_r, res_nxt;
	logic [31:0] instr_r, instr_nxt;
	logic trap_r, trap_nxt, irq_r, irq_nxt, done_r, done_nxt;
	logic first_r, first_nxt;
	coproc_pkg::kind_type kind;

	assign kind = coproc_pkg::decode_kind(instr_r);

	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		res_nxt = res_r;
		instr_nxt = instr_r;
		first_nxt = 1'b0;
		trap_nxt = 1'b0;
		irq_nxt = 1'b0;
		done_nxt = 1'b0;
		case (state_r)
			S_IDLE: begin
				if (start && cond_pass) begin // RULE_03
					state_nxt = S_WAIT;
					instr_nxt = instr;
					addr_nxt = base_addr;
					first_nxt = 1'b1;
				end
			end
			S_WAIT: begin
				if (!bus.coproc_absent && !bus.coproc_busy) begin // RULE_09
					case (kind)
						coproc_pkg::KIND_DATA_OP: begin
							state_nxt = S_IDLE; // RULE_11
							done_nxt = 1'b1;
						end
						coproc_pkg::KIND_REG_XFER: state_nxt = S_REG;
						default: state_nxt = S_XFER;
					endcase
				end else if (bus.coproc_absent && !first_r) begin
					state_nxt = S_IDLE; // RULE_05
					trap_nxt = 1'b1;
				end else if (irq && !first_r) begin
					state_nxt = S_IDLE; // RULE_07
					irq_nxt = 1'b1;
				end
			end
			S_XFER: begin
				// Interrupts are held off here
				if (bus.coproc_absent && bus.coproc_busy) begin // RULE_14 RULE_16
					state_nxt = S_IDLE;
					done_nxt = 1'b1;
				end else begin
					addr_nxt = addr_r + coproc_pkg::WORD_STEP;
				end
			end
			S_REG: begin
				if (bus.data_bus_enable) begin // RULE_18
					res_nxt = bus.bus_din;
					state_nxt = S_FIN;
				end
			end
			S_FIN: begin
				state_nxt = S_IDLE;
				done_nxt = 1'b1;
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin // RULE_08
		if (rst) begin
			state_r <= S_IDLE;
			addr_r <= coproc_pkg::ADDR_RESET;
			res_r <= coproc_pkg::INSTR_RESET;
			instr_r <= coproc_pkg::INSTR_RESET;
			first_r <= 1'b0;
			trap_r <= 1'b0;
			irq_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			res_r <= res_nxt;
			instr_r <= instr_nxt;
			first_r <= first_nxt;
			trap_r <= trap_nxt;
			irq_r <= irq_nxt;
			done_r <= done_nxt;
		end
	end

	// Strobe low only while waiting on the handshake
	assign bus.coproc_instr_strobe_n = (state_r != S_WAIT); // RULE_03 RULE_01
	assign bus.memory_request_n = (state_r == S_REG); // RULE_17
	assign bus.sequential_cycle = (state_r == S_REG) || (state_r == S_XFER);
	assign bus.opcode_fetch_n = !fetch;
	assign bus.translate_user_n = !user_mode;
	assign bus.addr = addr_r;
	assign bus.cpu_dout = store_word;
	// Only a register write towards the coprocessor is driven from here
	assign bus.cpu_doe = bus.data_bus_enable && (state_r == S_REG) &&
		!instr_r[coproc_pkg::LOAD_BIT];
	assign ready = (state_r == S_IDLE);
	assign undef_trap = trap_r;
	assign irq_taken = irq_r;
	assign done = done_r;
	assign reg_result = res_r;
endmodule

// *** tb/coproc_handshake_monitor.sv ***
// Checker for the handshake between the processor and coprocessor ends.
// Assumes one clock and a synchronous active-high reset on the interface.
`timescale 1ns/100ps

module coproc_handshake_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic coproc_instr_strobe_n,
	input wire logic coproc_absent,
	input wire logic coproc_busy,
	input wire logic data_bus_enable,
	input wire logic [31:0] addr,
	input wire logic cpu_doe,
	input wire logic cp_doe
);
	// ----------------------------------------------------------------
	// Handshake and bus properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	AST_BUSY_CLAIM: assert property (coproc_absent |-> coproc_busy)
		else $error("busy low without a claim");
	AST_IDLE_HIGH: assert property (($past(coproc_instr_strobe_n) &&
		coproc_instr_strobe_n && $past(coproc_absent)) |-> coproc_absent)
		else $error("absent low without a strobe");
	AST_TRAP: assert property ((!coproc_instr_strobe_n && coproc_absent)[*2]
		|=> coproc_instr_strobe_n)
		else $error("strobe held after no claim");
	AST_COMMIT: assert property ((!coproc_instr_strobe_n && !coproc_absent
		&& !coproc_busy) |=> coproc_instr_strobe_n)
		else $error("strobe held after commit");
	AST_DISCARD: assert property (($rose(coproc_instr_strobe_n) &&
		!$past(coproc_absent) && $past(coproc_busy)) |-> ##[0:2] coproc_absent)
		else $error("abandoned instruction kept");
	AST_DBE: assert property (cp_doe |-> data_bus_enable)
		else $error("bus driven without enable");
	AST_NO_CLASH: assert property (!(cp_doe && cpu_doe))
		else $error("both ends drive the bus");
	AST_DRIVE_READY: assert property (cp_doe |-> $past(!coproc_busy))
		else $error("bus driven before not busy");
	AST_ADDR_STEP: assert property ((coproc_instr_strobe_n && !coproc_absent
		&& !coproc_busy && $past(coproc_instr_strobe_n && !coproc_absent
		&& !coproc_busy)) |-> addr == $past(addr) + 32'h0000_0004)
		else $error("address step wrong");
endmodule

// *** tb/coproc_handshake_bench.sv ***
// Bench joining the processor end to one coprocessor end.
// Assumes the design package, interface and modules are compiled first.
`timescale 1ns/100ps

module coproc_handshake_bench;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	localparam logic [31:0] ONE = 32'h0000_0001;
	localparam logic [31:0] FOUR = 32'h0000_0004;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic start = 1'h0;
	logic cond_pass = 1'h1;
	logic irq = 1'h0;
	logic fetch = 1'h0;
	logic enabled = 1'h1;
	logic user_mode = 1'h0;
	logic [31:0] instr = 32'h0000_0000;
	logic [31:0] mem_word = 32'h0000_0000;
	logic [31:0] base_addr = 32'h0000_1000;
	logic [31:0] reg_value = 32'h1234_5678;
	logic ready, undef_trap, irq_taken, done, load_valid, committed, discarded;
	logic [31:0] reg_result, load_word;
	logic [31:0] n_done, n_trap, n_irq, n_com, n_disc, n_load, n_drv, n_stb;
	logic [31:0] n_idle;
	int bad_count = 0;
	int n_tests = 0;
	int irq_at = 2;

	coproc_if bus_if();
	assign bus_if.data_bus_enable = 1'h1;
	assign bus_if.bus_din = bus_if.cpu_doe ? bus_if.cpu_dout :
		bus_if.cp_doe ? bus_if.cp_dout : mem_word;

	cpu_end cpu_end_inst (.clk(clk), .rst(rst), .bus(bus_if.processor),
		.start(start), .cond_pass(cond_pass), .instr(instr),
		.base_addr(base_addr), .store_word(32'hCAFE_0001), .irq(irq),
		.user_mode(user_mode), .fetch(fetch), .ready(ready),
		.undef_trap(undef_trap), .irq_taken(irq_taken), .done(done),
		.reg_result(reg_result));
	coproc_end #(.WORDS(4), .PRIV_ONLY(1'b1)) coproc_end_inst (.clk(clk),
		.rst(rst),
		.bus(bus_if.coprocessor), .enabled(enabled), .reg_value(reg_value),
		.load_word(load_word), .load_valid(load_valid),
		.committed(committed), .discarded(discarded));
	coproc_handshake_monitor coproc_handshake_monitor_inst (.clk(clk),
		.rst(rst), .coproc_instr_strobe_n(bus_if.coproc_instr_strobe_n),
		.coproc_absent(bus_if.coproc_absent), .coproc_busy(bus_if.coproc_busy),
		.data_bus_enable(bus_if.data_bus_enable), .addr(bus_if.addr),
		.cpu_doe(bus_if.cpu_doe), .cp_doe(bus_if.cp_doe));

	always #4 clk = ~clk;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Fetch the word three times, issue it, then count events for 40 cycles
	task automatic run(input logic [31:0] ins, input logic cp, input logic iv);
		{n_done, n_trap, n_irq, n_com, n_disc, n_load, n_drv, n_stb} = '0;
		n_idle = '0;
		repeat (3) begin
			fetch = 1'h1;
			mem_word = ins;
			@(negedge clk);
		end
		fetch = 1'h0;
		mem_word = ~ins;
		while (ready !== 1'h1) @(negedge clk);
		start = 1'h1;
		cond_pass = cp;
		instr = ins;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			start = 1'h0;
			if (i == irq_at) irq = iv;
			if (irq_taken === 1'h1) irq = 1'h0;
			n_done += done;
			n_trap += undef_trap;
			n_irq += irq_taken;
			n_com += committed;
			n_disc += discarded;
			n_load += load_valid;
			n_drv += bus_if.cp_doe;
			n_stb += !bus_if.coproc_instr_strobe_n;
			n_idle += (bus_if.cp_doe | bus_if.cpu_doe) &
				bus_if.memory_request_n & bus_if.sequential_cycle;
			mem_word = mem_word + ONE;
		end
		irq = 1'h0;
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_data_op();
		run(32'h0E00_0100, 1'h1, 1'h0);
		check(n_done, ONE);
		check(n_com, ONE);
		check(n_trap, ZERO);
		check(n_drv, ZERO);
		$display("test data_op finished");
	endtask

	task automatic t_undef();
		logic [31:0] u [2] = '{32'h0600_0100, 32'h0E00_0F00};
		foreach (u[k]) begin
			run(u[k], 1'h1, 1'h0);
			check(n_trap, ONE);
			check(n_com, ZERO);
		end
		$display("test undef finished");
	endtask

	task automatic t_cond_fail();
		run(32'h0E00_0100, 1'h0, 1'h0);
		check(n_stb, ZERO);
		check(n_done, ZERO);
		$display("test cond_fail finished");
	endtask

	task automatic t_load();
		run(32'h0C10_0100, 1'h1, 1'h0);
		check(n_load, FOUR);
		check(n_done, ONE);
		check(load_word, 32'hF3EF_FF08);
		irq_at = 6;
		run(32'h0C10_0100, 1'h1, 1'h1);
		irq_at = 2;
		check(n_irq, ZERO);
		check(n_load, FOUR);
		$display("test load finished");
	endtask

	task automatic t_store();
		run(32'h0C00_0100, 1'h1, 1'h0);
		check(n_drv, FOUR);
		check(n_idle, ZERO);
		check(bus_if.addr, 32'h0000_100C);
		$display("test store finished");
	endtask

	task automatic t_reg();
		run(32'h0E10_0110, 1'h1, 1'h0);
		check(reg_result, reg_value);
		check({31'h0, n_idle != ZERO}, ONE);
		run(32'h0E00_0110, 1'h1, 1'h0);
		check(load_word, 32'hCAFE_0001);
		check(reg_result, 32'hCAFE_0001);
		check(n_drv, ZERO);
		$display("test reg finished");
	endtask

	task automatic t_irq();
		run(32'h0E00_0100, 1'h1, 1'h1);
		check(n_irq, ONE);
		check(n_disc, ONE);
		check(n_com, ZERO);
		run(32'h0E00_0100, 1'h1, 1'h0);
		check(n_done, ONE);
		$display("test irq finished");
	endtask

	task automatic t_off();
		enabled = 1'h0;
		run(32'h0E00_0100, 1'h1, 1'h0);
		check(n_trap, ONE);
		enabled = 1'h1;
		user_mode = 1'h1;
		run(32'h0E00_0100, 1'h1, 1'h0);
		check(n_trap, ONE);
		check(n_com, ZERO);
		user_mode = 1'h0;
		$display("test off finished");
	endtask

	initial begin
		repeat (6) @(negedge clk);
		rst = 1'h0;
		t_data_op();
		t_undef();
		t_cond_fail();
		t_load();
		t_store();
		t_reg();
		t_irq();
		t_off();
		summarize();
	end

	// Thirteen runs of about 45 cycles each fit well inside 2000 cycles
	initial begin
		#16000;
		bad_count++;
		summarize();
	end
endmodule
